// [hdl/pp_pkg.sv]
package pp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int WDOG_NS = 10_000;
  localparam int WDOG_CYC = WDOG_NS / CLK_NS;
  localparam int STB_NS = 500;
  localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int NEG_WAIT_US = 35_000;
  localparam int NEG_WAIT_DEF = NEG_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 21;
  localparam int WDOG_W = 10;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CONTROL = 3'h2;
  localparam logic [2:0] REG_EPP_ADDR = 3'h3;
  localparam logic [2:0] REG_EPP_DATA = 3'h4;
  localparam logic [2:0] REG_ECR = 3'h5;
  localparam logic [2:0] REG_NEG = 3'h6;
  localparam logic [2:0] REG_EPP_RD = 3'h7;
  localparam int ST_TIMEOUT = 0;
  localparam int CT_DIR = 5;
  localparam int CT_REV19 = 4;
  localparam int CT_SELIN = 3;
  localparam int CT_INIT = 2;
  localparam int CT_AUTOFD = 1;
  localparam int CT_STROBE = 0;
  localparam int NEG_START = 0;
  localparam int NEG_ECP = 1;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] XB_ECP = 8'h10;
  localparam logic [7:0] XB_EPP = 8'h40;

  // ----------------------------------------------------------------
  // FIFO
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [4:0] FIFO_THRESH = 5'h08;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SPP = 3'h0, MODE_BIDIR = 3'h1, MODE_FIFO = 3'h2, MODE_ECP = 3'h3,
    MODE_EPP = 3'h4, MODE_RSV5 = 3'h5, MODE_TEST = 3'h6, MODE_CFG = 3'h7
  } pp_mode_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_SETUP = 3'h1, HS_STROBE = 3'h3, HS_RELEASE = 3'h2,
    HS_RLE = 3'h6
  } pp_hs_t;
  typedef enum logic [1:0] {
    NG_IDLE = 2'h0, NG_REQ = 2'h1, NG_STB = 2'h3, NG_REL = 2'h2
  } pp_neg_t;
  typedef enum logic [1:0] {
    K_EPPW = 2'h0, K_EPPR = 2'h1, K_FWD = 2'h2, K_REV = 2'h3
  } pp_kind_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } pp_reg_req_t;
  typedef struct packed {
    logic [7:0] data_in;
    logic ack_intr_n;
    logic peripheral_busy_wait;
    logic paper_end_user;
    logic peripheral_selected;
    logic fault_request_n;
  } pp_pins_in_t;
  typedef struct packed {
    logic [7:0] data_out;
    logic data_oe;
    logic strobe_write_n;
    logic line_feed_data_strobe_n;
    logic init_reverse_n;
    logic select_in_addr_strobe_n;
  } pp_pins_out_t;
endpackage

// [hdl/pp_port.sv]
// Chosen here: the register offsets and the strobed register port.
module pp_port
  import pp_pkg::*;
#(
  parameter int NEG_WAIT_CYC = NEG_WAIT_DEF
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire pp_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // DMA
  input wire logic dma_ack,
  input wire logic [7:0] dma_wdata,
  output logic dma_req,
  output logic [7:0] dma_rdata,
  // Peripheral pins
  input wire pp_pins_in_t pins_in,
  output pp_pins_out_t pins_out
);

  typedef struct packed {
    pp_pins_in_t sync1;
    pp_pins_in_t sync2;
    pp_pins_in_t sync3;
    pp_pins_in_t pin;
    pp_pins_out_t out;
    logic [7:0] rdata;
    logic dma_req;
    logic [7:0] dma_rdata;
    logic [7:0] spp_data;
    logic [5:0] ctrl;
    pp_mode_t mode;
    logic dma_en;
    logic timeout;
    logic epp_ok;
    logic ecp_ok;
    pp_hs_t hs;
    pp_kind_t kind;
    logic hs_addr;
    logic hs_stb;
    logic hs_ack;
    logic [WDOG_W-1:0] wdog;
    logic [7:0] hs_byte;
    pp_neg_t neg;
    logic neg_ecp;
    logic [CNT_W-1:0] neg_cnt;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [6:0] rle_cnt;
    logic rle_pend;
    logic rle_run;
  } pp_state_t;

  pp_state_t s;
  pp_state_t next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Enhanced and extended modes fall back to standard until negotiated.
  function automatic pp_mode_t eff_mode(pp_mode_t m, logic epp, logic ecp);
    pp_mode_t r;
    r = m;
    if ((m == MODE_EPP && !epp) || (m == MODE_ECP && !ecp))
    begin
      r = MODE_SPP;
    end
    return r;
  endfunction

  function automatic logic is_hw(pp_mode_t m);
    return (m == MODE_FIFO) || (m == MODE_ECP);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic push;
    logic pop;
    logic [7:0] push_d;
    logic [12:0] agree;
    logic hw;
    logic dir;
    logic epp_go;
    pp_mode_t me;
    logic [7:0] head;
    push = 1'b0;
    pop = 1'b0;
    push_d = 8'h00;
    epp_go = 1'b0;
    next_s = s;
    me = eff_mode(s.mode, s.epp_ok, s.ecp_ok);
    hw = is_hw(me);
    dir = s.ctrl[CT_DIR];
    head = s.mem[s.rp];

    // Only the third stage and an agreeing second stage update a pin.
    next_s.sync1 = pins_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    agree = ~(s.sync2 ^ s.sync3);
    next_s.pin = pp_pins_in_t'((s.sync3 & agree) | (s.pin & ~agree));

    next_s.rdata = 8'h00;
    if (reg_req.re)
    begin
      case (reg_req.addr)
        REG_DATA:
        begin
          if (hw && dir)
          begin
            next_s.rdata = head;
            pop = 1'b1;
          end
          else if (me == MODE_BIDIR && dir)
          begin
            next_s.rdata = s.pin.data_in;
          end
          else
          begin
            next_s.rdata = s.spp_data;
          end
        end
        REG_STATUS: next_s.rdata = {s.pin.peripheral_busy_wait, s.pin.ack_intr_n,
          s.pin.paper_end_user, s.pin.peripheral_selected, s.pin.fault_request_n,
          1'b0, s.hs != HS_IDLE, s.timeout};
        REG_CONTROL: next_s.rdata = {2'b00, s.ctrl};
        REG_EPP_ADDR, REG_EPP_DATA: next_s.rdata = s.hs_byte;
        REG_ECR: next_s.rdata = {s.mode, 1'b0, s.dma_en, 1'b0,
          s.cnt == FIFO_FULL, s.cnt == 5'h00};
        REG_NEG: next_s.rdata = {5'h00, s.ecp_ok, s.epp_ok, s.neg != NG_IDLE};
        default: next_s.rdata = 8'h00;
      endcase
    end

    if (dma_ack && s.dma_en && hw)
    begin
      if (dir)
      begin
        next_s.dma_rdata = head;
        pop = 1'b1;
      end
      else
      begin
        push = 1'b1;
        push_d = dma_wdata;
      end
    end

    if (reg_req.we)
    begin
      case (reg_req.addr)
        REG_DATA:
        begin
          next_s.spp_data = reg_req.wdata;
          if (hw && !dir)
          begin
            push = 1'b1;
            push_d = reg_req.wdata;
          end
        end
        REG_STATUS:
        begin
          if (reg_req.wdata[ST_TIMEOUT])
          begin
            next_s.timeout = 1'b0;
          end
        end
        REG_CONTROL: next_s.ctrl = reg_req.wdata[5:0];
        REG_ECR:
        begin
          next_s.mode = pp_mode_t'(reg_req.wdata[7:5]);
          next_s.dma_en = reg_req.wdata[3];
          if (pp_mode_t'(reg_req.wdata[7:5]) == MODE_SPP)
          begin
            next_s.epp_ok = 1'b0;
            next_s.ecp_ok = 1'b0;
          end
        end
        REG_NEG:
        begin
          if (reg_req.wdata[NEG_START] && s.neg == NG_IDLE && s.hs == HS_IDLE)
          begin
            next_s.neg = NG_REQ;
            next_s.neg_ecp = reg_req.wdata[NEG_ECP];
            next_s.neg_cnt = '0;
          end
        end
        REG_EPP_ADDR, REG_EPP_DATA, REG_EPP_RD: epp_go = 1'b1;
        default: next_s.ctrl = s.ctrl;
      endcase
    end

    // ----------------------------------------------------------------
    // Hardware handshake
    // ----------------------------------------------------------------
    case (s.hs)
      HS_IDLE:
      begin
        next_s.wdog = '0;
        if (epp_go && me == MODE_EPP && s.neg == NG_IDLE)
        begin
          next_s.hs = HS_SETUP;
          next_s.kind = (reg_req.addr == REG_EPP_RD) ? K_EPPR : K_EPPW;
          next_s.hs_addr = (reg_req.addr == REG_EPP_RD) ? reg_req.wdata[0]
            : (reg_req.addr == REG_EPP_ADDR);
          if (reg_req.addr != REG_EPP_RD)
          begin
            next_s.hs_byte = reg_req.wdata;
          end
        end
        else if (hw && !dir && s.cnt != 5'h00 && !pop)
        begin
          pop = 1'b1;
          next_s.hs_byte = head;
          next_s.kind = K_FWD;
          next_s.hs = HS_SETUP;
        end
        else if (me == MODE_ECP && dir && !s.pin.ack_intr_n && s.cnt != FIFO_FULL)
        begin
          next_s.kind = K_REV;
          next_s.hs_ack = 1'b1;
          next_s.hs = HS_STROBE;
          if (!s.pin.peripheral_busy_wait)
          begin
            if (!s.pin.data_in[7])
            begin
              next_s.rle_cnt = s.pin.data_in[6:0];
              next_s.rle_pend = 1'b1;
            end
          end
          else if (s.rle_pend)
          begin
            next_s.hs_byte = s.pin.data_in;
            next_s.rle_pend = 1'b0;
            next_s.rle_run = 1'b1;
          end
          else
          begin
            push = 1'b1;
            push_d = s.pin.data_in;
          end
        end
      end
      HS_SETUP:
      begin
        // Revision 1.9 EPP cycles wait for the peripheral to be ready before strobing; forward FIFO bytes do not.
        if (!(s.kind != K_FWD && s.ctrl[CT_REV19] && s.pin.peripheral_busy_wait))
        begin
          next_s.hs_stb = 1'b1;
          next_s.hs = HS_STROBE;
        end
      end
      HS_STROBE:
      begin
        if (s.kind == K_REV)
        begin
          if (s.pin.ack_intr_n)
          begin
            next_s.hs_ack = 1'b0;
            next_s.hs = s.rle_run ? HS_RLE : HS_IDLE;
          end
        end
        else if (s.pin.peripheral_busy_wait)
        begin
          if (s.kind == K_EPPR)
          begin
            next_s.hs_byte = s.pin.data_in;
          end
          next_s.hs_stb = 1'b0;
          next_s.hs = HS_RELEASE;
        end
      end
      HS_RELEASE:
      begin
        if (!s.pin.peripheral_busy_wait)
        begin
          next_s.hs = HS_IDLE;
        end
      end
      HS_RLE:
      begin
        if (s.cnt != FIFO_FULL && !push)
        begin
          push = 1'b1;
          push_d = s.hs_byte;
          next_s.rle_cnt = s.rle_cnt - 7'h01;
          if (s.rle_cnt == 7'h00)
          begin
            next_s.rle_run = 1'b0;
            next_s.hs = HS_IDLE;
          end
        end
      end
      default: next_s.hs = HS_IDLE;
    endcase

    if (s.hs != HS_IDLE && (s.kind == K_EPPW || s.kind == K_EPPR))
    begin
      next_s.wdog = s.wdog + 1'b1;
      if (s.wdog == WDOG_W'(WDOG_CYC - 1))
      begin
        next_s.hs = HS_IDLE;
        next_s.hs_stb = 1'b0;
        next_s.timeout = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Negotiation
    // ----------------------------------------------------------------
    next_s.neg_cnt = s.neg_cnt + 1'b1;
    case (s.neg)
      NG_IDLE: next_s.neg_cnt = '0;
      NG_REQ:
      begin
        if (!s.pin.ack_intr_n && s.pin.paper_end_user && s.pin.fault_request_n
            && s.pin.peripheral_selected)
        begin
          next_s.neg = NG_STB;
          next_s.neg_cnt = '0;
        end
        else if (s.neg_cnt == CNT_W'(NEG_WAIT_CYC - 1))
        begin
          next_s.neg = NG_IDLE;
        end
      end
      NG_STB:
      begin
        if (s.neg_cnt == CNT_W'(STB_CYC - 1))
        begin
          next_s.neg = NG_REL;
          next_s.neg_cnt = '0;
        end
      end
      NG_REL:
      begin
        if (s.pin.ack_intr_n)
        begin
          next_s.neg = NG_IDLE;
          next_s.ecp_ok = s.neg_ecp ? s.pin.peripheral_selected : s.ecp_ok;
          next_s.epp_ok = s.neg_ecp ? s.epp_ok : s.pin.peripheral_selected;
        end
        else if (s.neg_cnt == CNT_W'(NEG_WAIT_CYC - 1))
        begin
          next_s.neg = NG_IDLE;
        end
      end
      default: next_s.neg = NG_IDLE;
    endcase

    // ----------------------------------------------------------------
    // FIFO update
    // ----------------------------------------------------------------
    if (!hw)
    begin
      push = 1'b0;
      pop = 1'b0;
      next_s.wp = 4'h0;
      next_s.rp = 4'h0;
      next_s.cnt = 5'h00;
      next_s.rle_pend = 1'b0;
      next_s.rle_run = 1'b0;
    end
    else
    begin
      push = push && (s.cnt != FIFO_FULL);
      pop = pop && (s.cnt != 5'h00);
      if (push)
      begin
        next_s.mem[s.wp] = push_d;
        next_s.wp = s.wp + 4'h1;
      end
      if (pop)
      begin
        next_s.rp = s.rp + 4'h1;
      end
      next_s.cnt = s.cnt + {4'h0, push} - {4'h0, pop};
    end

    // The request is taken from the updated count, so going forward it drops at the edge where the count reaches the threshold, and in reverse where it reaches zero.
    me = eff_mode(next_s.mode, next_s.epp_ok, next_s.ecp_ok);
    next_s.dma_req = next_s.dma_en && is_hw(me) && (next_s.ctrl[CT_DIR]
      ? next_s.cnt != 5'h00 : next_s.cnt < FIFO_THRESH);

    // ----------------------------------------------------------------
    // Pin roles
    // ----------------------------------------------------------------
    next_s.out.data_out = next_s.spp_data;
    next_s.out.data_oe = !(next_s.mode == MODE_BIDIR && next_s.ctrl[CT_DIR]);
    next_s.out.strobe_write_n = !next_s.ctrl[CT_STROBE];
    next_s.out.line_feed_data_strobe_n = !next_s.ctrl[CT_AUTOFD];
    next_s.out.init_reverse_n = !next_s.ctrl[CT_INIT];
    next_s.out.select_in_addr_strobe_n = !next_s.ctrl[CT_SELIN];
    if (next_s.neg != NG_IDLE)
    begin
      next_s.out.data_out = next_s.neg_ecp ? XB_ECP : XB_EPP;
      next_s.out.data_oe = 1'b1;
      next_s.out.select_in_addr_strobe_n = 1'b1;
      next_s.out.line_feed_data_strobe_n = next_s.neg == NG_REL;
      next_s.out.strobe_write_n = next_s.neg != NG_STB;
    end
    else if (me == MODE_EPP)
    begin
      next_s.out.data_out = next_s.hs_byte;
      next_s.out.data_oe = !(next_s.hs != HS_IDLE && next_s.kind == K_EPPR);
      next_s.out.strobe_write_n = !(next_s.hs != HS_IDLE && next_s.kind == K_EPPW);
      next_s.out.select_in_addr_strobe_n = !(next_s.hs_stb && next_s.hs_addr);
      next_s.out.line_feed_data_strobe_n = !(next_s.hs_stb && !next_s.hs_addr);
    end
    else if (is_hw(me))
    begin
      next_s.out.data_out = next_s.hs_byte;
      next_s.out.data_oe = !next_s.ctrl[CT_DIR];
      next_s.out.strobe_write_n = !next_s.hs_stb;
      if (me == MODE_ECP)
      begin
        next_s.out.line_feed_data_strobe_n = next_s.ctrl[CT_DIR] ? next_s.hs_ack : 1'b1;
        next_s.out.init_reverse_n = !next_s.ctrl[CT_DIR];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.out <= '{data_out: 8'h00, data_oe: 1'b1, strobe_write_n: 1'b1,
        line_feed_data_strobe_n: 1'b1, init_reverse_n: 1'b1,
        select_in_addr_strobe_n: 1'b1};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign dma_req = s.dma_req;
  assign dma_rdata = s.dma_rdata;
  assign pins_out = s.out;

endmodule // pp_port

// [testbench/pp_port_sva.sv]
module pp_port_sva
  import pp_pkg::*;
#(
  parameter int NEG_WAIT_CYC = NEG_WAIT_DEF
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire pp_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // DMA
  input wire logic dma_ack,
  input wire logic [7:0] dma_wdata,
  input wire logic dma_req,
  input wire logic [7:0] dma_rdata,
  // Peripheral pins
  input wire pp_pins_in_t pins_in,
  input wire pp_pins_out_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD_MAX = 420;
  logic [2:0] mode;
  logic [7:0] last_wr;
  logic [1:0] sw_age;
  logic ecr_wr;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  assign ecr_wr = reg_req.we && reg_req.addr == REG_ECR;
  // ----------------------------------------------------------------
  // Shadow of the mode field and the data latch
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode <= 3'h0;
      last_wr <= 8'h00;
      sw_age <= 2'h0;
    end
    else
    begin
      if (ecr_wr)
        mode <= reg_req.wdata[7:5];
      if (ecr_wr)
        sw_age <= 2'h0;
      else if (mode != 3'h2 && mode != 3'h3 && sw_age != 2'h3)
        sw_age <= sw_age + 2'h1;
      if (reg_req.we && reg_req.addr == REG_DATA)
        last_wr <= reg_req.wdata;
    end
  end
  property p_spp_data;
    reg_req.we && reg_req.addr == REG_DATA && mode == 3'h0
      |=> pins_out.data_out == $past(reg_req.wdata);
  endproperty
  a_spp_data: assert property (p_spp_data) else $error("data lines miss write");
  property p_spp_read;
    reg_req.re && reg_req.addr == REG_DATA && mode == 3'h0 |=> reg_rdata == last_wr;
  endproperty
  a_spp_read: assert property (p_spp_read) else $error("data read not last write");
  property p_ctl_pins;
    reg_req.we && reg_req.addr == REG_CONTROL && mode == 3'h0
      |=> {pins_out.select_in_addr_strobe_n, pins_out.init_reverse_n,
           pins_out.line_feed_data_strobe_n, pins_out.strobe_write_n}
          == ~$past(reg_req.wdata[3:0]);
  endproperty
  a_ctl_pins: assert property (p_ctl_pins) else $error("control lines wrong");
  property p_epp_refused;
    reg_req.we && reg_req.addr == REG_EPP_DATA && mode == 3'h0 |=> $stable(pins_out)[*4];
  endproperty
  a_epp_refused: assert property (p_epp_refused) else $error("cycle ran in mode 0");
  property p_status_lines;
    $stable({pins_in.peripheral_busy_wait, pins_in.ack_intr_n})[*8]
      ##0 (reg_req.re && reg_req.addr == REG_STATUS)
      |=> reg_rdata[7:6] == $past({pins_in.peripheral_busy_wait, pins_in.ack_intr_n});
  endproperty
  a_status_lines: assert property (p_status_lines) else $error("status lines wrong");
  property p_wdog;
    mode == 3'h4 && $fell(pins_out.line_feed_data_strobe_n)
      |-> ##[1:WD_MAX] pins_out.line_feed_data_strobe_n;
  endproperty
  a_wdog: assert property (p_wdog) else $error("data strobe stuck");
  property p_sw_dma;
    sw_age == 2'h3 |-> !dma_req;
  endproperty
  a_sw_dma: assert property (p_sw_dma) else $error("request in software mode");
  property p_ecp_hold;
    mode == 3'h3 && !pins_out.strobe_write_n |-> $stable(pins_out.data_out);
  endproperty
  a_ecp_hold: assert property (p_ecp_hold) else $error("data moved under strobe");
  c_dma: cover property ($rose(dma_req));
  c_wdog: cover property (mode == 3'h4 && $fell(pins_out.line_feed_data_strobe_n));
  c_ecp: cover property (mode == 3'h3 && $fell(pins_out.strobe_write_n));
endmodule // pp_port_sva

// [testbench/pp_periph.sv]
module pp_periph
  import pp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins
  input wire pp_pins_out_t host,
  output pp_pins_in_t pins_in,
  // Test controls
  input wire logic accept,
  input wire logic mute,
  input wire logic epp_mode,
  input wire logic [7:0] rd_byte,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sr;
  logic ack_n;
  logic paper;
  logic busy_q;
  logic [7:0] noise;
  logic strb;
  logic neg;
  logic busy;
  // In enhanced mode the write line frames the whole cycle, so only the strobes raise busy.
  assign strb = !(host.line_feed_data_strobe_n && host.select_in_addr_strobe_n
                  && (host.strobe_write_n || epp_mode));
  assign neg = host.data_oe && host.select_in_addr_strobe_n
               && (host.data_out == XB_ECP || host.data_out == XB_EPP);
  assign busy = sr[2] && !mute;
  // Released data lines carry a toggling pattern so a stale value never reads as good.
  assign pins_in = '{host.data_oe ? host.data_out : (sr[0] ? rd_byte : noise),
                     ack_n, busy, paper, accept, 1'b1};
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sr <= 3'h0;
      ack_n <= 1'b1;
      paper <= 1'b0;
      busy_q <= 1'b0;
      noise <= 8'h00;
      rx_byte <= 8'h00;
      rx_count <= 8'h00;
    end
    else
    begin
      sr <= {sr[1:0], strb};
      noise <= ~noise;
      paper <= neg;
      busy_q <= busy;
      ack_n <= !(neg && !host.line_feed_data_strobe_n);
      if (busy && !busy_q && host.data_oe)
      begin
        rx_byte <= host.data_out;
        rx_count <= rx_count + 8'h01;
      end
    end
  end
endmodule // pp_periph

// [testbench/ieee1284_parallel_port_tb.sv]
module ieee1284_parallel_port_tb
  import pp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, dma_ack, dma_req, accept, mute, epp;
  pp_reg_req_t reg_req;
  logic [7:0] reg_rdata, dma_wdata, dma_rdata, rd_byte, rx_byte, rx_count, rd, n0;
  pp_pins_in_t pins_in;
  pp_pins_out_t pins_out;
  logic [3:0] lines;
  int err_total = 0, comparisons = 0, as_cnt = 0, ds_cnt = 0, a0, d0;
  logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
  assign lines = {pins_out.select_in_addr_strobe_n, pins_out.init_reverse_n,
                  pins_out.line_feed_data_strobe_n, pins_out.strobe_write_n};
  always @(negedge pins_out.select_in_addr_strobe_n) as_cnt++;
  always @(negedge pins_out.line_feed_data_strobe_n) ds_cnt++;
  // The negotiation wait is cut to 200 cycles so a rejected peripheral times out quickly.
  pp_port #(.NEG_WAIT_CYC(200)) u_pp_port (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .dma_ack(dma_ack), .dma_wdata(dma_wdata), .dma_req(dma_req),
    .dma_rdata(dma_rdata), .pins_in(pins_in), .pins_out(pins_out));
  pp_periph u_pp_periph (.clock(clock), .rst_n(rst_n), .host(pins_out), .pins_in(pins_in),
    .accept(accept), .mute(mute), .epp_mode(epp), .rd_byte(rd_byte), .rx_byte(rx_byte),
    .rx_count(rx_count));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    reg_req.we <= 1'b0;
    #1;
  endtask
  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    reg_req.re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Every wait is bounded; running out counts as a failure, and in poll also ends the run.
  task automatic poll(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    int n;
    n = 0;
    d = ~v;
    while ((d & m) !== v && n < 600)
    begin
      rd8(a, d);
      n++;
    end
    if ((d & m) !== v)
    begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic wait_rx(input logic [7:0] n);
    int k;
    k = 0;
    while (rx_count !== n && k < 3000)
    begin
      @(posedge clock);
      k++;
    end
    chk("rx_count", rx_count, n);
  endtask
  task automatic negotiate(input logic ecp, input logic ok);
    accept <= ok;
    wr(REG_ECR, 8'h00);
    wr(REG_NEG, {6'h00, ecp, 1'b1});
    poll(REG_NEG, 8'h01, 8'h00);
    rd8(REG_NEG, rd);
    chk("neg_result", rd, {5'h00, ecp & ok, !ecp & ok, 1'b0});
  endtask
  task automatic dma_push(input logic [7:0] d);
    @(posedge clock);
    dma_ack <= 1'b1;
    dma_wdata <= d;
    @(posedge clock);
    dma_ack <= 1'b0;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    err_total++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_req = '0;
    dma_ack = 1'b0;
    dma_wdata = 8'h00;
    accept = 1'b1;
    mute = 1'b0;
    epp = 1'b0;
    rd_byte = 8'h00;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    rd8(REG_CONTROL, rd);
    chk("control", rd, {2'h0, CTRL_RST});
    chk("lines", {4'h0, lines}, 8'h0F);
    chk("dma_req", {7'h00, dma_req}, 8'h00);
    $display("Test reset done");
    foreach (pat[i])
    begin
      wr(REG_DATA, pat[i]);
      chk("data_out", pins_out.data_out, pat[i]);
      rd8(REG_DATA, rd);
      chk("data_back", rd, pat[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CONTROL, 8'h01 << i);
      chk("ctl_lines", {4'h0, lines}, 8'h0F ^ (8'h01 << i));
      repeat (8) @(posedge clock);
      rd8(REG_STATUS, rd);
      chk("busy_in", {7'h00, rd[7]}, {7'h00, i != 2});
    end
    wr(REG_CONTROL, 8'h00);
    repeat (10) @(posedge clock);
    rd8(REG_STATUS, rd);
    chk("busy_in", {7'h00, rd[7]}, 8'h00);
    $display("Test standard done");
    negotiate(1'b0, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      wr(REG_ECR, m ? 8'h80 : 8'h00);
      n0 = rx_count;
      wr(REG_EPP_DATA, 8'h3C);
      repeat (20) @(posedge clock);
      chk("epp_refused", rx_count, n0);
    end
    negotiate(1'b0, 1'b1);
    epp <= 1'b1;
    wr(REG_ECR, 8'h80);
    a0 = as_cnt;
    d0 = ds_cnt;
    for (int r = 0; r < 2; r++)
    begin
      wr(REG_CONTROL, r ? 8'h10 : 8'h00);
      n0 = rx_count;
      wr(REG_EPP_ADDR, 8'h20 + r);
      poll(REG_STATUS, 8'h02, 8'h00);
      chk("epp_addr", rx_byte, 8'h20 + r);
      wr(REG_EPP_DATA, 8'hC3 - r);
      poll(REG_STATUS, 8'h02, 8'h00);
      chk("epp_data", rx_byte, 8'hC3 - r);
      chk("epp_count", rx_count, n0 + 8'h02);
      rd_byte <= 8'h96 + r;
      wr(REG_EPP_RD, 8'h00);
      poll(REG_STATUS, 8'h02, 8'h00);
      rd8(REG_EPP_DATA, rd);
      chk("epp_read", rd, 8'h96 + r);
    end
    chk("addr_strobes", 8'(as_cnt - a0), 8'h02);
    chk("data_strobes", 8'(ds_cnt - d0), 8'h04);
    $display("Test enhanced done");
    mute <= 1'b1;
    wr(REG_EPP_DATA, 8'h11);
    repeat (380) @(posedge clock);
    rd8(REG_STATUS, rd);
    chk("wdog_run", rd & 8'h03, 8'h02);
    repeat (40) @(posedge clock);
    rd8(REG_STATUS, rd);
    chk("wdog_exp", rd & 8'h03, 8'h01);
    wr(REG_STATUS, 8'h01);
    rd8(REG_STATUS, rd);
    chk("to_clear", rd & 8'h03, 8'h00);
    mute <= 1'b0;
    $display("Test watchdog done");
    epp <= 1'b0;
    negotiate(1'b1, 1'b1);
    wr(REG_ECR, 8'h68);
    repeat (4) @(posedge clock);
    chk("dma_on", {7'h00, dma_req}, 8'h01);
    mute <= 1'b1;
    n0 = rx_count;
    for (int i = 0; i < 10; i++)
      dma_push(8'h40 + i);
    repeat (3) @(posedge clock);
    chk("dma_thresh", {7'h00, dma_req}, 8'h00);
    rd8(REG_ECR, rd);
    chk("not_empty", rd & 8'h01, 8'h00);
    mute <= 1'b0;
    wait_rx(n0 + 8'h0A);
    chk("ecp_last", rx_byte, 8'h49);
    rd8(REG_ECR, rd);
    chk("empty", rd & 8'h01, 8'h01);
    chk("dma_again", {7'h00, dma_req}, 8'h01);
    wr(REG_DATA, 8'h7E);
    wait_rx(n0 + 8'h0B);
    chk("pio_byte", rx_byte, 8'h7E);
    wr(REG_ECR, 8'h08);
    repeat (3) @(posedge clock);
    chk("dma_sw", {7'h00, dma_req}, 8'h00);
    rd8(REG_ECR, rd);
    chk("sw_empty", rd & 8'h01, 8'h01);
    $display("Test extended done");
    end_sim();
  end
endmodule // ieee1284_parallel_port_tb
bind pp_port pp_port_sva #(.NEG_WAIT_CYC(NEG_WAIT_CYC)) u_pp_port_sva (.clock(clock),
  .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .dma_ack(dma_ack),
  .dma_wdata(dma_wdata), .dma_req(dma_req), .dma_rdata(dma_rdata), .pins_in(pins_in),
  .pins_out(pins_out));
